// ### src/ssb_defs.vh
// Purpose: shared constants of the pipelined burst synchronous memory
// Assumes: included by its bare name from the design file
// Notes:   widths, sizes, positions and fixed levels and values, no logic
`ifndef SSB_DEFS_VH
`define SSB_DEFS_VH

// array organisation
`define SSB_ADDR_W      19
`define SSB_DEPTH       524288
`define SSB_LANES       4
`define SSB_LANE_W      9
`define SSB_DATA_W      8
`define SSB_WORD_W      36
`define SSB_BURST_W     2

// write buffer entry layout {address, lane enables, word} and buffer depth
`define SSB_ENT_WORD_LSB 0
`define SSB_ENT_LANE_LSB 36
`define SSB_ENT_ADDR_LSB 40
`define SSB_ENT_W        59
`define SSB_BUF_DEPTH    2

// burst order select level that picks interleaved sequencing
`define SSB_ORDER_INTERLEAVE 1'b1

// idle, all-lanes and burst step values
`define SSB_LANES_NONE  4'h0
`define SSB_LANES_ALL   4'hf
`define SSB_BURST_ZERO  2'h0
`define SSB_BURST_ONE   2'h1

`endif

// ### src/ssb_sram.v
// Purpose: pipelined burst synchronous static memory, 512K x 36, at pins
// Assumes: controller logic runs on clk_i; sleep is a true async pin
// Notes:   byte lanes are 8 data bits plus parity; bus pins are split
//          into input, output and output enable signals
`timescale 1ns/1ns
`include "ssb_defs.vh"

// two-entry buffer between the write input register and the array
module ssb_buf2 #(
  parameter W = `SSB_ENT_W
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         rst_n_i,
  // fill side
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  // drain side
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0] ent0_r;
  reg [W-1:0] ent1_r;
  reg         head_r;
  reg         tail_r;
  reg [1:0]   count_r;
  wire        push;
  wire        pop;

  assign in_ready_o  = (count_r != 2'h2);
  assign out_valid_o = (count_r != 2'h0);
  assign out_data_o  = head_r ? ent1_r : ent0_r;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // entry storage, no reset needed on the data
  always @(posedge clk_i) begin
    if (push & ~tail_r)
      ent0_r <= in_data_i;
    if (push & tail_r)
      ent1_r <= in_data_i;
  end

  // pointers and occupancy
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      head_r  <= 1'b0;
      tail_r  <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (push)
        tail_r <= ~tail_r;
      if (pop)
        head_r <= ~head_r;
      if (push & ~pop)
        count_r <= count_r + 2'h1;
      else if (pop & ~push)
        count_r <= count_r - 2'h1;
    end
  end
endmodule

module ssb_sram #(
  parameter ADDR_W = `SSB_ADDR_W,
  parameter DEPTH  = `SSB_DEPTH
) (
  // clock and reset
  input  wire              clk_i,
  input  wire              rst_n_i,
  // address and selects
  input  wire [ADDR_W-1:0] addr_i,
  input  wire              chip_select_low_first_i,
  input  wire              chip_select_high_i,
  input  wire              chip_select_low_third_i,
  // burst control
  input  wire              processor_address_strobe_n_i,
  input  wire              controller_address_strobe_n_i,
  input  wire              burst_advance_n_i,
  input  wire              burst_order_interleave_i,
  // write controls
  input  wire              all_lanes_write_n_i,
  input  wire              lane_write_function_n_i,
  input  wire              lane_a_write_select_n_i,
  input  wire              lane_b_write_select_n_i,
  input  wire              lane_c_write_select_n_i,
  input  wire              lane_d_write_select_n_i,
  // asynchronous controls
  input  wire              output_enable_n_i,
  input  wire              sleep_request_i,
  // lane a bus
  input  wire [7:0]        lane_a_data_i,
  output wire [7:0]        lane_a_data_o,
  output wire              lane_a_data_oe_o,
  input  wire              lane_a_parity_i,
  output wire              lane_a_parity_o,
  output wire              lane_a_parity_oe_o,
  // lane b bus
  input  wire [7:0]        lane_b_data_i,
  output wire [7:0]        lane_b_data_o,
  output wire              lane_b_data_oe_o,
  input  wire              lane_b_parity_i,
  output wire              lane_b_parity_o,
  output wire              lane_b_parity_oe_o,
  // lane c bus
  input  wire [7:0]        lane_c_data_i,
  output wire [7:0]        lane_c_data_o,
  output wire              lane_c_data_oe_o,
  input  wire              lane_c_parity_i,
  output wire              lane_c_parity_o,
  output wire              lane_c_parity_oe_o,
  // lane d bus
  input  wire [7:0]        lane_d_data_i,
  output wire [7:0]        lane_d_data_o,
  output wire              lane_d_data_oe_o,
  input  wire              lane_d_parity_i,
  output wire              lane_d_parity_o,
  output wire              lane_d_parity_oe_o,
  // status
  output wire              write_accept_o,
  output wire              sleep_active_o
);
  localparam LW = `SSB_LANE_W;
  localparam WW = `SSB_WORD_W;
  // entry width follows the address width, so a shortened array still fits
  localparam EW = `SSB_ENT_ADDR_LSB + ADDR_W;

  // access pipeline state
  reg  [ADDR_W-1:0] base_addr_r;
  reg  [1:0]        seed_r;
  reg  [1:0]        burst_cnt_r;
  reg               active_r;
  reg  [ADDR_W-1:0] acc_addr_r;
  reg               rd_req_r;
  reg  [WW-1:0]     dout_r;
  reg               dvalid_r;
  // sleep synchroniser
  reg               sleep_meta_r;
  reg               sleep_sync_r;
  // next values
  reg  [1:0]        seed_nxt;
  reg  [1:0]        burst_cnt_nxt;
  reg  [ADDR_W-1:0] base_addr_nxt;
  reg               active_nxt;
  reg               acc_go;
  reg               acc_wr;
  // decoded controls
  wire              chip_sel;
  wire              proc_start;
  wire              ctrl_start;
  wire [3:0]        lane_sel;
  wire [3:0]        lane_wr;
  wire [1:0]        burst_low;
  wire [ADDR_W-1:0] acc_addr;
  wire [WW-1:0]     din;
  wire [WW-1:0]     rd_word;
  wire              drive;
  // write buffer wiring
  wire              wb_in_ready;
  wire              wb_out_valid;
  wire [EW-1:0]     wb_out;
  wire [ADDR_W-1:0] wb_addr;
  wire [3:0]        wb_lanes;
  wire [WW-1:0]     wb_word;

  // chip select and strobe qualification
  assign chip_sel   = ~chip_select_low_first_i & chip_select_high_i &
                      ~chip_select_low_third_i;
  assign proc_start = ~processor_address_strobe_n_i &
                      ~chip_select_low_first_i;
  assign ctrl_start = ~controller_address_strobe_n_i & ~proc_start;

  // lane write decode; global write wins over lane controls
  assign lane_sel = ~{lane_d_write_select_n_i, lane_c_write_select_n_i,
                      lane_b_write_select_n_i, lane_a_write_select_n_i};
  assign lane_wr  = ~all_lanes_write_n_i ? `SSB_LANES_ALL :
                    ~lane_write_function_n_i ? lane_sel :
                    `SSB_LANES_NONE;

  // lane a at bit 0; each lane is data then parity in the top bit
  assign din = {lane_d_parity_i, lane_d_data_i, lane_c_parity_i, lane_c_data_i,
                lane_b_parity_i, lane_b_data_i, lane_a_parity_i,
                lane_a_data_i};

  // burst sequence from seed and count, order pin read directly
  assign burst_low = (burst_order_interleave_i == `SSB_ORDER_INTERLEAVE) ?
                     (seed_nxt ^ burst_cnt_nxt) :
                     (seed_nxt + burst_cnt_nxt);
  assign acc_addr  = {base_addr_nxt[ADDR_W-1:2], burst_low};

  // per-edge decode of strobes, advance and write controls
  always @* begin
    seed_nxt      = seed_r;
    burst_cnt_nxt = burst_cnt_r;
    base_addr_nxt = base_addr_r;
    active_nxt    = active_r;
    acc_go        = 1'b0;
    acc_wr        = 1'b0;
    if (sleep_sync_r) begin
      active_nxt = 1'b0;
    end else if (proc_start | ctrl_start) begin
      active_nxt = chip_sel;
      if (chip_sel) begin
        base_addr_nxt = addr_i;
        seed_nxt      = addr_i[1:0];
        burst_cnt_nxt = `SSB_BURST_ZERO;
        acc_go        = 1'b1;
        // processor strobe: write controls ignored on its first cycle
        acc_wr        = ctrl_start & (lane_wr != `SSB_LANES_NONE);
      end
    end else if (active_r) begin
      acc_go = 1'b1;
      if (~burst_advance_n_i)
        burst_cnt_nxt = burst_cnt_r + `SSB_BURST_ONE;
      acc_wr = (lane_wr != `SSB_LANES_NONE);
    end
  end

  // sleep pin through two flip-flops before the control logic
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sleep_meta_r <= 1'b0;
      sleep_sync_r <= 1'b0;
    end else begin
      sleep_meta_r <= sleep_request_i;
      sleep_sync_r <= sleep_meta_r;
    end
  end

  // address, control and burst registers: first pipeline stage
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_addr_r <= {ADDR_W{1'b0}};
      seed_r      <= `SSB_BURST_ZERO;
      burst_cnt_r <= `SSB_BURST_ZERO;
      active_r    <= 1'b0;
      acc_addr_r  <= {ADDR_W{1'b0}};
      rd_req_r    <= 1'b0;
    end else begin
      base_addr_r <= base_addr_nxt;
      seed_r      <= seed_nxt;
      burst_cnt_r <= burst_cnt_nxt;
      active_r    <= active_nxt;
      acc_addr_r  <= acc_addr;
      rd_req_r    <= acc_go & ~acc_wr;
    end
  end

  // output register: second stage, word from last cycle's address
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dout_r   <= {WW{1'b0}};
      dvalid_r <= 1'b0;
    end else begin
      if (rd_req_r)
        dout_r <= rd_word;
      dvalid_r <= rd_req_r;
    end
  end

  // write input register and buffer; entry formed at the sampling edge
  ssb_buf2 #(
    .W (EW)
  ) u_wbuf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (acc_wr),
    .in_ready_o  (wb_in_ready),
    .in_data_i   ({acc_addr, lane_wr, din}),
    .out_valid_o (wb_out_valid),
    .out_ready_i (~sleep_sync_r),
    .out_data_o  (wb_out)
  );

  assign wb_addr  = wb_out[`SSB_ENT_ADDR_LSB +: ADDR_W];
  assign wb_lanes = wb_out[`SSB_ENT_LANE_LSB +: 4];
  assign wb_word  = wb_out[`SSB_ENT_WORD_LSB +: WW];

  // storage array as four 9-bit lanes, written independently
  genvar g;
  generate
    for (g = 0; g < `SSB_LANES; g = g + 1) begin : g_lane
      reg [LW-1:0] mem [0:DEPTH-1];
      // self-timed commit on the edge, no external pulse
      always @(posedge clk_i) begin
        if (wb_out_valid & ~sleep_sync_r & wb_lanes[g])
          mem[wb_addr] <= wb_word[g*LW +: LW];
      end
      assign rd_word[g*LW +: LW] = mem[acc_addr_r];
    end
  endgenerate

  // drivers: clocked valid gated directly by output enable and sleep;
  // the controller turns the bus around by raising output enable
  assign drive = dvalid_r & ~output_enable_n_i &
                 ~sleep_request_i;

  assign lane_a_data_o      = dout_r[7:0];
  assign lane_a_parity_o    = dout_r[8];
  assign lane_b_data_o      = dout_r[16:9];
  assign lane_b_parity_o    = dout_r[17];
  assign lane_c_data_o      = dout_r[25:18];
  assign lane_c_parity_o    = dout_r[26];
  assign lane_d_data_o      = dout_r[34:27];
  assign lane_d_parity_o    = dout_r[35];
  assign lane_a_data_oe_o   = drive;
  assign lane_a_parity_oe_o = drive;
  assign lane_b_data_oe_o   = drive;
  assign lane_b_parity_oe_o = drive;
  assign lane_c_data_oe_o   = drive;
  assign lane_c_parity_oe_o = drive;
  assign lane_d_data_oe_o   = drive;
  assign lane_d_parity_oe_o = drive;

  // status
  assign write_accept_o = wb_in_ready;
  assign sleep_active_o = sleep_sync_r;
endmodule

// ### verification/ssb_sram_asserts.sv
// Purpose: pin timing checks on the pipelined burst memory
// Assumes: bound to ssb_sram, single clock domain
// Notes:   driver enables are sampled at rising edges only
`timescale 1ns/1ns
module ssb_sram_asserts (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // access controls
  input wire chip_select_low_first_i,
  input wire chip_select_high_i,
  input wire chip_select_low_third_i,
  input wire processor_address_strobe_n_i,
  input wire controller_address_strobe_n_i,
  input wire all_lanes_write_n_i,
  input wire lane_write_function_n_i,
  input wire output_enable_n_i,
  input wire sleep_request_i,
  // observed outputs
  input wire lane_a_data_oe_o,
  input wire lane_a_parity_oe_o,
  input wire lane_d_parity_oe_o,
  input wire sleep_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // decoded strobe, select and read-start conditions
  wire sel_w = !chip_select_low_first_i && chip_select_high_i &&
               !chip_select_low_third_i;
  wire prc_w = !processor_address_strobe_n_i && !chip_select_low_first_i;
  wire eff_w = (prc_w || !controller_address_strobe_n_i) && !sleep_active_o;
  wire rd_w  = eff_w && sel_w &&
               (prc_w || (all_lanes_write_n_i && lane_write_function_n_i));
  wire oe_w  = lane_a_data_oe_o;
  wire on_w  = !output_enable_n_i && !sleep_request_i;

  oe_gate_a: assert property (output_enable_n_i |-> !oe_w)
    else $error("driver on while output enable is high");
  sleep_drop_a: assert property (sleep_request_i |-> !oe_w)
    else $error("driver on while sleep is requested");
  lane_oe_a: assert property (oe_w == lane_a_parity_oe_o &&
    oe_w == lane_d_parity_oe_o)
    else $error("lane driver enables disagree");
  read_load_a: assert property (rd_w ##2 on_w |-> oe_w)
    else $error("read data not driven one cycle after access");
  desel_release_a: assert property (eff_w && !sel_w |-> ##2 !oe_w)
    else $error("bus not released one cycle after deselect");
  ctrl_write_a: assert property (eff_w && sel_w &&
    processor_address_strobe_n_i && !all_lanes_write_n_i |-> ##2 !oe_w)
    else $error("controller write drove the bus");
  both_strb_a: assert property (prc_w && sel_w &&
    !controller_address_strobe_n_i && !sleep_active_o ##2 on_w |-> oe_w)
    else $error("processor strobe did not win over controller strobe");
  sleep_sync_a: assert property (
    sleep_request_i [*4] |-> sleep_active_o)
    else $error("sleep status late");
  wake_clear_a: assert property (
    !sleep_request_i [*4] |-> !sleep_active_o)
    else $error("sleep status stuck");
endmodule

bind ssb_sram ssb_sram_asserts u_sva (
  .clk_i, .rst_n_i, .chip_select_low_first_i, .chip_select_high_i,
  .chip_select_low_third_i, .processor_address_strobe_n_i,
  .controller_address_strobe_n_i, .all_lanes_write_n_i,
  .lane_write_function_n_i, .output_enable_n_i, .sleep_request_i,
  .lane_a_data_oe_o, .lane_a_parity_oe_o, .lane_d_parity_oe_o,
  .sleep_active_o
);

// ### verification/ssb_ctl_model.sv
// Purpose: controller side of the shared data bus
// Assumes: one driver enable per 9-bit lane from the memory
// Notes:   a released line shows the inverse of its last level
`timescale 1ns/1ns
module ssb_ctl_model (
  // clock
  input  wire        clk_i,
  // memory side
  input  wire [35:0] dev_q_i,
  input  wire [3:0]  dev_oe_i,
  // controller side
  input  wire        ctl_drive_i,
  input  wire [35:0] ctl_d_i,
  // resolved bus and contention flag
  output reg  [35:0] bus_o,
  output reg         clash_o
);
  reg     [35:0] last_r;
  integer        i;

  // resolve each bit from its lane driver; floating lines wander
  always @* begin
    for (i = 0; i < 36; i = i + 1) begin
      if (dev_oe_i[i/9])
        bus_o[i] = dev_q_i[i];
      else if (ctl_drive_i)
        bus_o[i] = ctl_d_i[i];
      else
        bus_o[i] = ~last_r[i];
    end
  end

  // remember the bus and flag two drivers at once
  initial begin
    last_r = 36'h0;
    clash_o = 1'b0;
  end
  always @(posedge clk_i) begin
    last_r <= bus_o;
    if (ctl_drive_i && |dev_oe_i)
      clash_o <= 1'b1;
  end
endmodule

// ### verification/ssb_sram_bench.sv
// Purpose: self-checking bench for the burst memory
// Assumes: array shortened to 1024 words
// Notes:   words are {lane d, c, b, a}, 9 bits a lane
`timescale 1ns/1ns
module ssb_sram_bench;
  // control codes {pstb, cstb, stp, alln, lfn, lsel}
  localparam [8:0]  IDLE = 9'h1ff;
  localparam [8:0]  PRD  = 9'h0ff;
  localparam [8:0]  CRD  = 9'h17f;
  localparam [8:0]  CWR  = 9'h15f;
  localparam [8:0]  STEP = 9'h1bf;
  localparam [8:0]  PWR  = 9'h1df;
  localparam [35:0] W8   = 36'h5a5a00000;

  reg         clk, rst_n, pstb, cstb, stp, alln, lfn;
  reg         ord, oe_n, slp_req, drv;
  reg  [2:0]  sel;
  reg  [3:0]  lsel;
  reg  [9:0]  a;
  reg  [35:0] wd;
  wire [35:0] q, bus;
  wire [7:0]  doe;
  wire [3:0]  qoe;
  wire        clash, wacc, slp_act;
  integer     err_total, comparisons;

  assign qoe = {doe[7] & doe[6], doe[5] & doe[4], doe[3] & doe[2],
                doe[1] & doe[0]};

  ssb_sram #(.ADDR_W(10), .DEPTH(1024)) dut (
    .clk_i(clk), .rst_n_i(rst_n), .addr_i(a),
    .chip_select_low_first_i(sel[2]), .chip_select_high_i(sel[1]),
    .chip_select_low_third_i(sel[0]),
    .processor_address_strobe_n_i(pstb),
    .controller_address_strobe_n_i(cstb),
    .burst_advance_n_i(stp), .burst_order_interleave_i(ord),
    .all_lanes_write_n_i(alln), .lane_write_function_n_i(lfn),
    .lane_a_write_select_n_i(lsel[0]), .lane_b_write_select_n_i(lsel[1]),
    .lane_c_write_select_n_i(lsel[2]), .lane_d_write_select_n_i(lsel[3]),
    .output_enable_n_i(oe_n), .sleep_request_i(slp_req),
    .lane_a_data_i(bus[7:0]), .lane_a_parity_i(bus[8]),
    .lane_a_data_o(q[7:0]), .lane_a_parity_o(q[8]),
    .lane_a_data_oe_o(doe[0]), .lane_a_parity_oe_o(doe[1]),
    .lane_b_data_i(bus[16:9]), .lane_b_parity_i(bus[17]),
    .lane_b_data_o(q[16:9]), .lane_b_parity_o(q[17]),
    .lane_b_data_oe_o(doe[2]), .lane_b_parity_oe_o(doe[3]),
    .lane_c_data_i(bus[25:18]), .lane_c_parity_i(bus[26]),
    .lane_c_data_o(q[25:18]), .lane_c_parity_o(q[26]),
    .lane_c_data_oe_o(doe[4]), .lane_c_parity_oe_o(doe[5]),
    .lane_d_data_i(bus[34:27]), .lane_d_parity_i(bus[35]),
    .lane_d_data_o(q[34:27]), .lane_d_parity_o(q[35]),
    .lane_d_data_oe_o(doe[6]), .lane_d_parity_oe_o(doe[7]),
    .write_accept_o(wacc), .sleep_active_o(slp_act)
  );

  ssb_ctl_model u_ctl (
    .clk_i(clk), .dev_q_i(q), .dev_oe_i(qoe), .ctl_drive_i(drv),
    .ctl_d_i(wd), .bus_o(bus), .clash_o(clash)
  );

  // free-running clock
  always #5 clk = ~clk;

  task end_sim;
    begin
      if (err_total == 0 && comparisons > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  task chk(input [35:0] got, input [35:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // one bus cycle; the bus is only driven with output enable high
  task op(input [8:0] k, input [9:0] ad, input [35:0] d);
    begin
      {pstb, cstb, stp, alln, lfn, lsel} = k;
      a = ad;
      wd = d;
      drv = ~alln | (~lfn & ~&lsel);
      oe_n = drv;
      @(posedge clk);
      #1;
    end
  endtask

  task rd(input [9:0] ad, input [35:0] exp);
    begin
      op(PRD, ad, 36'h0);
      op(IDLE, 10'h0, 36'h0);
      chk(bus, exp);
    end
  endtask

  task desel;
    begin
      sel = 3'b011;
      op(CRD, 10'h0, 36'h0);
      sel = 3'b010;
      op(IDLE, 10'h0, 36'h0);
    end
  endtask

  task t_global;
    begin
      op(CWR, 10'h3ff, 36'h9a5c31e7b);
      op(CWR, 10'h000, 36'h0f0f0f0f0);
      rd(10'h3ff, 36'h9a5c31e7b);
      rd(10'h000, 36'h0f0f0f0f0);
    end
  endtask

  task t_lanes;
    reg     [35:0] e;
    integer        k;
    begin
      e = 36'h0;
      op(CWR, 10'h005, e);
      for (k = 0; k < 4; k = k + 1) begin
        op({5'h16, ~(4'h1 << k)}, 10'h005, ~36'h0);
        e = e | (36'h1ff << (9 * k));
        rd(10'h005, e);
      end
      op(9'h16f, 10'h005, 36'h0);
      rd(10'h005, e);
      op(9'h14e, 10'h005, 36'h123456789);
      rd(10'h005, 36'h123456789);
    end
  endtask

  task t_burst;
    reg     [1:0]  lo;
    reg     [19:0] seq;
    integer        i, o;
    begin
      // low address bits seen from seed 1: linear 1,2,2,3,0 then
      // interleaved 1,0,0,3,2; the second cycle holds the address
      seq = 20'hb04e9;
      for (i = 0; i < 4; i = i + 1)
        op(CWR, {8'h02, i[1:0]}, {32'h5a5a0000, 2'h0, i[1:0]});
      for (o = 0; o < 2; o = o + 1) begin
        ord = o[0];
        op(PRD, 10'h009, 36'h0);
        for (i = 1; i < 6; i = i + 1) begin
          op((i == 2) ? IDLE : STEP, 10'h0, 36'h0);
          lo = seq[o * 10 + i * 2 - 2 +: 2];
          chk(bus, {32'h5a5a0000, 2'h0, lo});
        end
        desel;
      end
    end
  endtask

  task t_desel;
    integer j;
    begin
      for (j = 0; j < 3; j = j + 1) begin
        rd(10'h008, W8);
        sel = (j == 0) ? 3'b110 : (j == 1) ? 3'b000 : 3'b011;
        op(CRD, 10'h008, 36'h0);
        sel = 3'b010;
        chk(bus, W8);
        op(IDLE, 10'h0, 36'h0);
        chk({28'h0, doe}, 36'h0);
      end
      // ignored processor strobe must let the running burst go on
      rd(10'h008, W8);
      sel = 3'b110;
      op(PRD, 10'h008, 36'h0);
      sel = 3'b010;
      op(IDLE, 10'h0, 36'h0);
      chk(bus, W8);
    end
  endtask

  task t_pwrite;
    begin
      op(CWR, 10'h021, W8);
      op(9'h0df, 10'h021, 36'h3c3c3c3c3);
      op(IDLE, 10'h0, 36'h0);
      chk(bus, W8);
      desel;
      op(PRD, 10'h020, 36'h0);
      op(PWR, 10'h3ff, 36'h2468ace13);
      rd(10'h020, 36'h2468ace13);
    end
  endtask

  task t_both;
    begin
      op(CWR, 10'h030, 36'h111111111);
      op(9'h05f, 10'h030, 36'h222222222);
      op(IDLE, 10'h0, 36'h0);
      chk(bus, 36'h111111111);
      desel;
      rd(10'h030, 36'h111111111);
    end
  endtask

  task t_oe_sleep;
    begin
      rd(10'h008, W8);
      oe_n = 1'b1;
      #2 chk({28'h0, doe}, 36'h0);
      @(posedge clk);
      #1 oe_n = 1'b0;
      #2 chk(bus, W8);
      @(posedge clk);
      #1 slp_req = 1'b1;
      #2 chk({28'h0, doe}, 36'h0);
      repeat (6) op(IDLE, 10'h0, 36'h0);
      chk({26'h0, doe, slp_act, wacc}, 36'h3);
      slp_req = 1'b0;
      repeat (6) op(IDLE, 10'h0, 36'h0);
      chk({35'h0, slp_act}, 36'h0);
      rd(10'h008, W8);
    end
  endtask

  // cut a hang short well past the expected run length
  initial begin
    #50000;
    err_total = err_total + 1;
    end_sim;
  end

  // reset, then the scenarios in turn
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {pstb, cstb, stp, alln, lfn, lsel} = IDLE;
    sel = 3'b010;
    a = 10'h0;
    wd = 36'h0;
    {ord, oe_n, slp_req, drv} = 4'h0;
    err_total = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    t_global;
    t_lanes;
    t_burst;
    t_desel;
    t_pwrite;
    t_both;
    t_oe_sleep;
    chk({34'h0, clash, wacc}, 36'h1);
    end_sim;
  end
endmodule
